// *** inc/branch_pkg.sv ***
// Constants and types shared by the program-flow unit and its condition evaluator
// Operation
// - Conditional jump loads target when condition true, else next sequential instruction.
// - Carry set/clear test C; unsigned above is C and not Z, complement otherwise.
// - Zero-set is Z equal 1; unequal is Z equal 0.
// - Nonnegative/negative test S; overflow set/clear test O.
// - Signed at-least when S xor O is 0; signed below when 1.
// - Signed above when (S xor O) or Z is 0; at-most when 1.
// - Conditional reach -127..+128, or -126..+129 for signed and overflow tests.
// - Unconditional jump forms: short +2..+9, byte, word, absolute 20-bit.
// - Word indirect jump goes to start plus sign-extended source; memory gives 2 bytes.
// - Absolute indirect jump or call reads 3 memory bytes, loads them into PC.
// - Memory target read from lowest-order byte upward at increasing addresses.
// - Direct call accepts word-relative -32767..+32768 or absolute 20-bit target.
// - Word indirect call goes to start plus sign-extended source; memory gives 2 bytes.
// - Control-register load copies source to selected register; memory gives 2 bytes.
// - No interrupt accepted at boundary right after a control-register load.
// - Control-register load changes flags only when destination is flag register.
// - Stack pointer load writes user or interrupt SP chosen by U flag.
package branch_pkg;

  localparam int FLG_C = 0;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_O = 5;
  localparam int FLG_U = 7;

  localparam logic [19:0] PC_RST = 20'h00000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [19:0] INTB_RST = 20'h00000;
  localparam logic [15:0] FLG_RST = 16'h0000;

  localparam int SHORT_MIN = 2;
  localparam int SHORT_MAX = 9;
  localparam int BYTE_MIN = -127;
  localparam int BYTE_MAX = 128;
  localparam int SCMP_MIN = -126;
  localparam int SCMP_MAX = 129;
  localparam int WORD_MIN = -32767;
  localparam int WORD_MAX = 32768;

  localparam logic [1:0] WORD_LAST = 2'h1;
  localparam logic [1:0] ABS_LAST = 2'h2;
  localparam logic [15:0] SP_HI_STEP = 16'h0001;
  localparam logic [15:0] SP_LO_STEP = 16'h0002;

  typedef enum logic [2:0] {
    JUMP_ON_CONDITION, UNCONDITIONAL_BRANCH, JUMP_INDIRECT_OP,
    CALL_DIRECT, CALL_INDIRECT, LOAD_CONTROL_REG
  } op_t;

  typedef enum logic [3:0] {
    CARRY_SET_COND, CARRY_CLEAR_COND, ZERO_SET_COND, UNEQUAL_COND,
    UNSIGNED_ABOVE_COND, UNSIGNED_NOT_ABOVE_COND, NONNEGATIVE_COND, NEGATIVE_COND,
    SIGNED_AT_LEAST_COND, SIGNED_AT_MOST_COND, SIGNED_ABOVE_COND, SIGNED_BELOW_COND,
    OVERFLOW_SET_COND, OVERFLOW_CLEAR_COND
  } cond_t;

  typedef enum logic [1:0] {LEN_SHORT, LEN_BYTE, LEN_WORD, LEN_ABS} len_t;

  typedef enum logic [2:0] {
    VECTOR_BASE_LOW, VECTOR_BASE_HIGH, FLAG_REGISTER,
    CR_INT_SP, CR_SP, CR_STATIC_BASE, CR_FRAME_BASE
  } creg_t;

  typedef struct packed {
    op_t op;
    cond_t cond;
    len_t len;
    creg_t creg;
    logic src_mem;
    logic [19:0] src_val;
    logic [19:0] src_addr;
    logic signed [17:0] disp;
    logic [19:0] start;
    logic [2:0] n;
  } cmd_t;

  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

endpackage : branch_pkg

// *** rtl/cond_eval.sv ***
// Branch condition evaluator over the C, Z, S and O flags
`timescale 1ns/10ps
module cond_eval
  import branch_pkg::*;
(
  input wire logic [15:0] flags_i,
  input wire cond_t cond_i,
  output logic take_o,
  output logic wide_o
);

  logic c;
  logic z;
  logic s;
  logic o;

  always_comb begin
    c = flags_i[FLG_C];
    z = flags_i[FLG_Z];
    s = flags_i[FLG_S];
    o = flags_i[FLG_O];
    take_o = 1'b0;
    wide_o = 1'b0;
    unique case (cond_i)
      CARRY_SET_COND: take_o = c;
      CARRY_CLEAR_COND: take_o = ~c;
      UNSIGNED_ABOVE_COND: take_o = c & ~z;
      UNSIGNED_NOT_ABOVE_COND: take_o = ~(c & ~z);
      ZERO_SET_COND: take_o = z;
      UNEQUAL_COND: take_o = ~z;
      NONNEGATIVE_COND: take_o = ~s;
      NEGATIVE_COND: take_o = s;
      OVERFLOW_SET_COND: begin
        take_o = o;
        wide_o = 1'b1;
      end
      OVERFLOW_CLEAR_COND: begin
        take_o = ~o;
        wide_o = 1'b1;
      end
      SIGNED_AT_LEAST_COND: begin
        take_o = ~(s ^ o);
        wide_o = 1'b1;
      end
      SIGNED_BELOW_COND: begin
        take_o = s ^ o;
        wide_o = 1'b1;
      end
      SIGNED_ABOVE_COND: begin
        take_o = ~((s ^ o) | z);
        wide_o = 1'b1;
      end
      SIGNED_AT_MOST_COND: begin
        take_o = (s ^ o) | z;
        wide_o = 1'b1;
      end
      // Unused codes never branch
      default: take_o = 1'b0;
    endcase
  end

endmodule : cond_eval

// *** rtl/branch_call_ctrlreg_unit.sv ***
// Program-flow unit: conditional and direct jumps, indirect jumps, calls, control loads
`timescale 1ns/10ps
module branch_call_ctrlreg_unit
  import branch_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CMD_VALID_I,
  input wire cmd_t CMD_I,
  input wire logic FLAGS_WE_I,
  input wire logic [15:0] FLAGS_I,
  input wire logic MEM_ACK_I,
  input wire logic [7:0] MEM_RDATA_I,
  output mem_req_t MEM_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic ERR_O,
  output logic IRQ_BLOCK_O,
  output logic [19:0] PC_O,
  output logic [15:0] FLAGS_O,
  output logic [15:0] USP_O,
  output logic [15:0] ISP_O,
  output logic [15:0] SB_O,
  output logic [15:0] FB_O,
  output logic [19:0] INTB_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [1:0] {IDLE, FETCH, PUSH_HI, PUSH_LO} state_t;

  state_t state, next_state;
  cmd_t cmd, cur;
  mem_req_t mem, next_mem;
  logic [23:0] fetched, next_fetched, val;
  logic [1:0] byte_cnt, last_idx;
  logic [19:0] pc, ret, ret_val, call_tgt, target, intb;
  logic [15:0] flag_register, usp, isp, sp_sel, sb, fb;
  logic acc, ack, needs_mem, bad, fetch_done, exec, take, wide, done, blk;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic in_range(input logic signed [17:0] d, input int lo, input int hi);
    return (int'(d) >= lo) && (int'(d) <= hi);
  endfunction : in_range

  function automatic logic is_call(input op_t op);
    return (op == CALL_DIRECT) || (op == CALL_INDIRECT);
  endfunction : is_call

  // Illegal reaches are refused whole, so no partial update can leak out
  function automatic logic reach_ok(input cmd_t c, input logic w);
    logic ok;
    ok = 1'b1;
    unique case (c.op)
      JUMP_ON_CONDITION: begin
        ok = w ? in_range(c.disp, SCMP_MIN, SCMP_MAX)
               : in_range(c.disp, BYTE_MIN, BYTE_MAX);
      end
      UNCONDITIONAL_BRANCH: begin
        unique case (c.len)
          LEN_SHORT: ok = in_range(c.disp, SHORT_MIN, SHORT_MAX);
          LEN_BYTE: ok = in_range(c.disp, BYTE_MIN, BYTE_MAX);
          LEN_WORD: ok = in_range(c.disp, WORD_MIN, WORD_MAX);
          LEN_ABS: ok = 1'b1;
        endcase
      end
      CALL_DIRECT: begin
        ok = (c.len == LEN_ABS) ||
             ((c.len == LEN_WORD) && in_range(c.disp, WORD_MIN, WORD_MAX));
      end
      JUMP_INDIRECT_OP, CALL_INDIRECT: ok = (c.len == LEN_WORD) || (c.len == LEN_ABS);
      LOAD_CONTROL_REG: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : reach_ok

  ////////////////////////////////////////////////////////////////////////////////
  // Condition evaluation
  cond_eval u_cond_eval (
    .flags_i(flag_register),
    .cond_i(cur.cond),
    .take_o(take),
    .wide_o(wide)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode
  always_comb begin
    cur = (state == IDLE) ? CMD_I : cmd;
    acc = (state == IDLE) && CMD_VALID_I;
    ack = mem.req && MEM_ACK_I;
    needs_mem = CMD_I.src_mem && ((CMD_I.op == JUMP_INDIRECT_OP) ||
                (CMD_I.op == CALL_INDIRECT) || (CMD_I.op == LOAD_CONTROL_REG));
    bad = acc && !reach_ok(CMD_I, wide);
    // Only absolute indirect targets span three bytes
    last_idx = ((cmd.op != LOAD_CONTROL_REG) && (cmd.len == LEN_ABS)) ? ABS_LAST
                                                                     : WORD_LAST;
    fetch_done = (state == FETCH) && ack && (byte_cnt == last_idx);
    exec = (acc && !needs_mem && !bad) || fetch_done;
    sp_sel = flag_register[FLG_U] ? usp : isp;
    ret_val = cur.start + 20'(cur.n);
  end

  always_comb begin
    next_fetched = fetched;
    next_fetched[{byte_cnt, 3'b000} +: 8] = MEM_RDATA_I;
    val = fetch_done ? next_fetched : {4'h0, CMD_I.src_val};
  end

  // Destination of the current jump or call
  always_comb begin
    target = cur.start;
    unique case (cur.op)
      JUMP_INDIRECT_OP, CALL_INDIRECT: begin
        if (cur.len == LEN_ABS) begin
          target = val[19:0];
        end else begin
          target = cur.start + {{4{val[15]}}, val[15:0]};
        end
      end
      UNCONDITIONAL_BRANCH, CALL_DIRECT: begin
        target = (cur.len == LEN_ABS) ? cur.src_val : cur.start + 20'(cur.disp);
      end
      JUMP_ON_CONDITION: begin
        target = take ? cur.start + 20'(cur.disp) : ret_val;
      end
      default: target = ret_val;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        if (acc && !bad) begin
          if (needs_mem) begin
            next_state = FETCH;
          end else if (is_call(CMD_I.op)) begin
            next_state = PUSH_HI;
          end
        end
      end
      FETCH: begin
        if (fetch_done) begin
          next_state = is_call(cmd.op) ? PUSH_HI : IDLE;
        end
      end
      PUSH_HI: begin
        if (ack) begin
          next_state = PUSH_LO;
        end
      end
      PUSH_LO: begin
        if (ack) begin
          next_state = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cmd <= '0;
    end else if (acc) begin
      cmd <= CMD_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory requests: one transfer per cycle with req and ack both high
  always_comb begin
    next_mem = mem;
    if (ack) begin
      next_mem.req = 1'b0;
    end
    if ((state == IDLE) && (next_state == FETCH)) begin
      next_mem.req = 1'b1;
      next_mem.we = 1'b0;
      next_mem.word = 1'b0;
      next_mem.addr = CMD_I.src_addr;
    end else if ((state == FETCH) && (next_state == FETCH) && ack) begin
      next_mem.req = 1'b1;
      next_mem.addr = mem.addr + 20'h00001;
    end
    if ((state != PUSH_HI) && (next_state == PUSH_HI)) begin
      next_mem.req = 1'b1;
      next_mem.we = 1'b1;
      next_mem.word = 1'b0;
      next_mem.addr = {4'h0, sp_sel - SP_HI_STEP};
      next_mem.wdata = {12'h000, ret_val[19:16]};
    end else if ((state == PUSH_HI) && ack) begin
      next_mem.req = 1'b1;
      next_mem.we = 1'b1;
      next_mem.word = 1'b1;
      next_mem.addr = {4'h0, sp_sel - SP_HI_STEP - SP_LO_STEP};
      next_mem.wdata = ret[15:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mem <= '0;
    end else begin
      mem <= next_mem;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fetched <= 24'h000000;
      byte_cnt <= 2'h0;
    end else if (acc) begin
      fetched <= 24'h000000;
      byte_cnt <= 2'h0;
    end else if ((state == FETCH) && ack) begin
      fetched <= next_fetched;
      byte_cnt <= byte_cnt + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Program counter and pending call
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pc <= PC_RST;
    end else if (exec) begin
      if (is_call(cur.op)) begin
        pc <= pc;
      end else if (cur.op == LOAD_CONTROL_REG) begin
        pc <= ret_val;
      end else begin
        pc <= target;
      end
    end else if ((state == PUSH_LO) && ack) begin
      pc <= call_tgt;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ret <= 20'h00000;
      call_tgt <= 20'h00000;
    end else if (exec && is_call(cur.op)) begin
      ret <= ret_val;
      call_tgt <= target;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stack pointers
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      usp <= SP_RST;
      isp <= SP_RST;
    end else if (exec && (cur.op == LOAD_CONTROL_REG) && (cur.creg == CR_INT_SP)) begin
      isp <= val[15:0];
    end else if (exec && (cur.op == LOAD_CONTROL_REG) && (cur.creg == CR_SP)) begin
      if (flag_register[FLG_U]) begin
        usp <= val[15:0];
      end else begin
        isp <= val[15:0];
      end
    end else if (ack && ((state == PUSH_HI) || (state == PUSH_LO))) begin
      // Stepping in place keeps SP right even if the push is stretched
      if (flag_register[FLG_U]) begin
        usp <= usp - ((state == PUSH_HI) ? SP_HI_STEP : SP_LO_STEP);
      end else begin
        isp <= isp - ((state == PUSH_HI) ? SP_HI_STEP : SP_LO_STEP);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Other control registers
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flag_register <= FLG_RST;
    end else if (exec && (cur.op == LOAD_CONTROL_REG) && (cur.creg == FLAG_REGISTER)) begin
      flag_register <= val[15:0];
    end else if (FLAGS_WE_I) begin
      // Only the arithmetic path writes here; jumps and calls never do
      flag_register <= FLAGS_I;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sb <= BASE_RST;
      fb <= BASE_RST;
    end else if (exec && (cur.op == LOAD_CONTROL_REG)) begin
      if (cur.creg == CR_STATIC_BASE) begin
        sb <= val[15:0];
      end
      if (cur.creg == CR_FRAME_BASE) begin
        fb <= val[15:0];
      end
    end
  end

  // Halves land independently; software pairs them back to back
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      intb <= INTB_RST;
    end else if (exec && (cur.op == LOAD_CONTROL_REG)) begin
      if (cur.creg == VECTOR_BASE_LOW) begin
        intb[15:0] <= val[15:0];
      end
      if (cur.creg == VECTOR_BASE_HIGH) begin
        intb[19:16] <= val[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status
  always_comb begin
    done = (exec && !is_call(cur.op)) || ((state == PUSH_LO) && ack) || bad;
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DONE_O <= 1'b0;
      ERR_O <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      DONE_O <= done;
      ERR_O <= bad;
      BUSY_O <= (next_state != IDLE);
    end
  end

  // Held from the load's end until the next command is taken
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      blk <= 1'b0;
    end else if (exec && (cur.op == LOAD_CONTROL_REG)) begin
      blk <= 1'b1;
    end else if (acc) begin
      blk <= 1'b0;
    end
  end

  assign IRQ_BLOCK_O = blk;
  assign MEM_O = mem;
  assign PC_O = pc;
  assign FLAGS_O = flag_register;
  assign USP_O = usp;
  assign ISP_O = isp;
  assign SB_O = sb;
  assign FB_O = fb;
  assign INTB_O = intb;

endmodule : branch_call_ctrlreg_unit

// *** dv/flow_monitor.sv ***
// Port checker for the program-flow unit
`timescale 1ns/10ps
module flow_monitor
  import branch_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CMD_VALID_I,
  input wire cmd_t CMD_I,
  input wire logic FLAGS_WE_I,
  input wire logic MEM_ACK_I,
  input wire mem_req_t MEM_O,
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic ERR_O,
  input wire logic IRQ_BLOCK_O,
  input wire logic [19:0] PC_O,
  input wire logic [15:0] FLAGS_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  logic take;
  logic fload;
  assign take = CMD_VALID_I && !BUSY_O;
  assign fload = take && CMD_I.op == LOAD_CONTROL_REG && CMD_I.creg == FLAG_REGISTER;
  ////////////////////////////////////////////////////////////////////////////////
  a_err_has_done: assert property (ERR_O |-> DONE_O)
    else $error("refusal without done");
  a_refuse_keeps: assert property (ERR_O |-> $stable(PC_O) &&
    ($stable(FLAGS_O) || $past(FLAGS_WE_I))) else $error("refusal changed state");
  // Memory-source flag loads land while reading, so read cycles are excluded
  a_flags_kept: assert property (!$past(FLAGS_WE_I) && !$past(fload) &&
    !$past(BUSY_O && !MEM_O.we) |-> $stable(FLAGS_O)) else $error("flags changed");
  a_flag_load: assert property (fload && !CMD_I.src_mem
    |=> FLAGS_O == $past(CMD_I.src_val[15:0])) else $error("flag load wrong");
  a_load_blocks: assert property (take && CMD_I.op == LOAD_CONTROL_REG && !CMD_I.src_mem
    |=> IRQ_BLOCK_O && DONE_O) else $error("no block after load");
  a_block_cause: assert property ($rose(IRQ_BLOCK_O) |-> DONE_O)
    else $error("block without completion");
  a_busy_ends: assert property ($fell(BUSY_O) |-> DONE_O) else $error("busy fell early");
  a_busy_bound: assert property ($rose(BUSY_O) |-> ##[1:200] DONE_O) else $error("hung");
  a_read_upward: assert property (MEM_O.req && !MEM_O.we && MEM_ACK_I |=>
    !MEM_O.req || MEM_O.we || MEM_O.addr == $past(MEM_O.addr) + 20'h1) else $error("read order");
  a_push_order: assert property (MEM_O.req && MEM_O.we && !MEM_O.word && MEM_ACK_I |=>
    MEM_O.req && MEM_O.we && MEM_O.word && MEM_O.addr == $past(MEM_O.addr) - 20'h2)
    else $error("push order");
  a_req_held: assert property (MEM_O.req && !MEM_ACK_I |=> MEM_O.req && $stable(MEM_O))
    else $error("request dropped");
  a_cond_answer: assert property (take && CMD_I.op == JUMP_ON_CONDITION |=> DONE_O)
    else $error("no jump answer");
  c_push: cover property (MEM_O.req && MEM_O.we && MEM_O.word && MEM_ACK_I);
  c_refuse: cover property (ERR_O);
  c_block: cover property ($rose(IRQ_BLOCK_O));
endmodule : flow_monitor

bind branch_call_ctrlreg_unit flow_monitor u_flow_monitor (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I),
  .FLAGS_WE_I(FLAGS_WE_I), .MEM_ACK_I(MEM_ACK_I), .MEM_O(MEM_O), .BUSY_O(BUSY_O),
  .DONE_O(DONE_O), .ERR_O(ERR_O), .IRQ_BLOCK_O(IRQ_BLOCK_O), .PC_O(PC_O), .FLAGS_O(FLAGS_O)
);

// *** dv/mem_model.sv ***
// Byte-wide memory standing for program, data and stack memory
`timescale 1ns/10ps
module mem_model
  import branch_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mem_req_t mem_i,
  input wire logic [1:0] stall_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:4095];
  logic [1:0] wait_cnt;
  logic [7:0] last;
  assign ack_o = mem_i.req && wait_cnt == stall_i;
  // Idle cycles show the inverse byte so a stale read cannot pass
  assign rdata_o = (ack_o && !mem_i.we) ? mem[mem_i.addr[11:0]] : ~last;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 2'h0;
      last <= 8'h00;
    end else if (ack_o) begin
      wait_cnt <= 2'h0;
      last <= rdata_o;
      if (mem_i.we) begin
        mem[mem_i.addr[11:0]] <= mem_i.wdata[7:0];
        if (mem_i.word) begin
          mem[mem_i.addr[11:0] + 12'h1] <= mem_i.wdata[15:8];
        end
      end
    end else if (mem_i.req) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : mem_model

// *** dv/tb.sv ***
// Self-checking bench for the program-flow unit
`timescale 1ns/10ps
module tb
  import branch_pkg::*;
;
  logic clk, rst, cmd_valid, flags_we, ack, busy, done, err, irq_block, got_err;
  cmd_t cmd;
  mem_req_t mem_bus;
  logic [15:0] flags_in, flags, usp, isp, sb, fb;
  logic [7:0] rdata;
  logic [19:0] pc, intb;
  logic [1:0] stall;
  int failures, total_checks;
  branch_call_ctrlreg_unit u_branch_call_ctrlreg_unit (.SYS_CLK_I(clk), .RST_I(rst),
    .CMD_VALID_I(cmd_valid), .CMD_I(cmd), .FLAGS_WE_I(flags_we), .FLAGS_I(flags_in),
    .MEM_ACK_I(ack), .MEM_RDATA_I(rdata), .MEM_O(mem_bus), .BUSY_O(busy), .DONE_O(done),
    .ERR_O(err), .IRQ_BLOCK_O(irq_block), .PC_O(pc), .FLAGS_O(flags), .USP_O(usp),
    .ISP_O(isp), .SB_O(sb), .FB_O(fb), .INTB_O(intb));
  mem_model u_mem_model (.clk_i(clk), .rst_i(rst), .mem_i(mem_bus), .stall_i(stall),
    .ack_o(ack), .rdata_o(rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk_val(input logic [19:0] got, input logic [19:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    chk_val({19'h0, got}, {19'h0, exp}, msg);
  endtask : chk_bit
  function automatic cmd_t mk(op_t op, len_t ln, logic sm, logic [19:0] v, logic [19:0] a,
    int d, logic [19:0] st, logic [2:0] n, cond_t cd = CARRY_SET_COND, creg_t cr = CR_FRAME_BASE);
    return '{op, cd, ln, cr, sm, v, a, 18'(d), st, n};
  endfunction : mk
  function automatic cmd_t ld(creg_t cr, logic [19:0] v);
    return mk(LOAD_CONTROL_REG, LEN_WORD, 1'b0, v, 20'h0, 0, 20'h00600, 3'h2, CARRY_SET_COND, cr);
  endfunction : ld
  function automatic logic cond_exp(cond_t cd, logic [15:0] f);
    logic c, z, x;
    logic [13:0] t;
    c = f[FLG_C];
    z = f[FLG_Z];
    x = f[FLG_S] ^ f[FLG_O];
    t = {!f[FLG_O], f[FLG_O], x, !(x | z), x | z, !x, f[FLG_S], !f[FLG_S], !(c & !z), c & !z,
      !z, z, !c, c};
    return t[cd];
  endfunction : cond_exp
  // Waits on the completion pulse; a missing one ends the run
  task automatic issue(input cmd_t c);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    for (i = 0; i < 300 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: no completion", $time);
      test_done();
    end else begin
      got_err = err;
    end
  endtask : issue
  task automatic set_flags(input logic [15:0] v);
    @(posedge clk);
    flags_we <= 1'b1;
    flags_in <= v;
    @(posedge clk);
    flags_we <= 1'b0;
  endtask : set_flags
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_cond();
    logic [15:0] f;
    for (int k = 0; k < 16; k++) begin
      f = {10'h000, k[3], 1'b0, k[2], k[1], 1'b0, k[0]};
      set_flags(f);
      for (int j = 0; j < 14; j++) begin
        issue(mk(JUMP_ON_CONDITION, LEN_BYTE, 1'b0, 20'h0, 20'h0, 16, 20'h00100, 3'h2,
          cond_t'(j)));
        chk_val(pc, cond_exp(cond_t'(j), f) ? 20'h00110 : 20'h00102, "cond");
        chk_val({4'h0, flags}, {4'h0, f}, "flags");
      end
    end
    $display("test cond done");
  endtask : t_cond
  task automatic t_reach();
    int d [20] = '{-127, 128, -128, 129, -126, 129, -127, 130, 2, 9, 1, 10, -127, 128, -128,
      129, -32767, 32768, -32768, 32769};
    int g;
    logic [19:0] p;
    set_flags(16'h0001);
    for (int i = 0; i < 20; i++) begin
      g = i / 4;
      p = pc;
      issue(mk(g < 2 ? JUMP_ON_CONDITION : UNCONDITIONAL_BRANCH,
        g == 2 ? LEN_SHORT : (g == 4 ? LEN_WORD : LEN_BYTE), 1'b0, 20'h0, 20'h0, d[i],
        20'h40000, 3'h2, g == 1 ? SIGNED_AT_LEAST_COND : CARRY_SET_COND));
      chk_bit(got_err, (i % 4) > 1, "refusal");
      chk_val(pc, (i % 4) > 1 ? p : 20'h40000 + 20'(d[i]), "reach");
    end
    p = pc;
    issue(mk(CALL_DIRECT, LEN_WORD, 1'b0, 20'h0, 20'h0, -32768, 20'h40000, 3'h3));
    chk_bit(got_err, 1'b1, "call reach");
    chk_val(pc, p, "call refused");
    $display("test reach done");
  endtask : t_reach
  task automatic t_ctrl();
    issue(ld(FLAG_REGISTER, 20'h00080));
    chk_val({4'h0, flags}, 20'h00080, "flag load");
    chk_bit(irq_block, 1'b1, "block");
    chk_val(pc, 20'h00602, "load pc");
    issue(ld(CR_SP, 20'h01000));
    chk_val({4'h0, usp}, 20'h01000, "usp");
    chk_val({4'h0, flags}, 20'h00080, "flags kept");
    issue(ld(FLAG_REGISTER, 20'h00000));
    issue(ld(CR_SP, 20'h02000));
    chk_val({4'h0, isp}, 20'h02000, "isp");
    chk_val({4'h0, usp}, 20'h01000, "usp kept");
    issue(ld(CR_INT_SP, 20'h02100));
    issue(ld(CR_FRAME_BASE, 20'h01234));
    issue(ld(VECTOR_BASE_LOW, 20'h05678));
    issue(ld(VECTOR_BASE_HIGH, 20'h0000A));
    chk_val({4'h0, isp}, 20'h02100, "isp load");
    chk_val({4'h0, fb}, 20'h01234, "fb");
    chk_val(intb, 20'hA5678, "vector base");
    stall = 2'h1;
    issue(mk(LOAD_CONTROL_REG, LEN_WORD, 1'b1, 20'h0, 20'h00300, 0, 20'h00600, 3'h2,
      CARRY_SET_COND, CR_STATIC_BASE));
    chk_val({4'h0, sb}, 20'h0ABCD, "sb memory");
    issue(ld(FLAG_REGISTER, 20'h00080));
    issue(mk(UNCONDITIONAL_BRANCH, LEN_SHORT, 1'b0, 20'h0, 20'h0, 2, 20'h00700, 3'h1));
    chk_bit(irq_block, 1'b0, "block cleared");
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_ind();
    stall = 2'h0;
    issue(mk(JUMP_INDIRECT_OP, LEN_WORD, 1'b1, 20'h0, 20'h00100, 0, 20'h00500, 3'h2));
    chk_val(pc, 20'h004FE, "ind mem");
    issue(mk(JUMP_INDIRECT_OP, LEN_WORD, 1'b0, 20'h08000, 20'h0, 0, 20'h10010, 3'h2));
    chk_val(pc, 20'h08010, "ind reg");
    stall = 2'h2;
    issue(mk(JUMP_INDIRECT_OP, LEN_ABS, 1'b1, 20'h0, 20'h00200, 0, 20'h00500, 3'h3));
    chk_val(pc, 20'hA3456, "ind abs");
    issue(mk(UNCONDITIONAL_BRANCH, LEN_ABS, 1'b0, 20'hBCDE1, 20'h0, 0, 20'h00500, 3'h4));
    chk_val(pc, 20'hBCDE1, "jmp abs");
    $display("test indirect done");
  endtask : t_ind
  task automatic t_call();
    stall = 2'h1;
    issue(mk(CALL_INDIRECT, LEN_ABS, 1'b1, 20'h0, 20'h00200, 0, 20'h12340, 3'h3));
    chk_val(pc, 20'hA3456, "call abs");
    chk_val({4'h0, usp}, 20'h00FFD, "sp");
    chk_val({u_mem_model.mem[12'hFFF][3:0], u_mem_model.mem[12'hFFE],
      u_mem_model.mem[12'hFFD]}, 20'h12343, "ret");
    stall = 2'h0;
    issue(mk(CALL_DIRECT, LEN_WORD, 1'b0, 20'h0, 20'h0, 256, 20'h01000, 3'h3));
    chk_val(pc, 20'h01100, "call word");
    chk_val({4'h0, usp}, 20'h00FFA, "sp2");
    chk_val({u_mem_model.mem[12'hFFC][3:0], u_mem_model.mem[12'hFFB],
      u_mem_model.mem[12'hFFA]}, 20'h01003, "ret2");
    issue(mk(CALL_INDIRECT, LEN_WORD, 1'b0, 20'h0FFF0, 20'h0, 0, 20'h03000, 3'h2));
    chk_val(pc, 20'h02FF0, "call ind");
    chk_val({4'h0, usp}, 20'h00FF7, "sp3");
    issue(mk(CALL_DIRECT, LEN_ABS, 1'b0, 20'h54321, 20'h0, 0, 20'h03000, 3'h4));
    chk_val(pc, 20'h54321, "call abs20");
    chk_val({4'h0, usp}, 20'h00FF4, "sp4");
    chk_val({4'h0, isp}, 20'h02100, "isp kept");
    chk_val({4'h0, flags}, 20'h00080, "flags");
    $display("test call done");
  endtask : t_call
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst, cmd_valid, flags_we, flags_in, stall, failures, total_checks} = '0;
    rst = 1'b1;
    cmd = '0;
    u_mem_model.mem[12'h100] = 8'hFE;
    u_mem_model.mem[12'h101] = 8'hFF;
    u_mem_model.mem[12'h200] = 8'h56;
    u_mem_model.mem[12'h201] = 8'h34;
    u_mem_model.mem[12'h202] = 8'h0A;
    u_mem_model.mem[12'h300] = 8'hCD;
    u_mem_model.mem[12'h301] = 8'hAB;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_val(pc, PC_RST, "reset pc");
    t_cond();
    t_reach();
    t_ctrl();
    t_ind();
    t_call();
    test_done();
  end
endmodule : tb
